//--- hdl/gpd_defs.svh
// register indices, field positions and reset values of the gpio port data block
`ifndef GPD_DEFS_SVH
`define GPD_DEFS_SVH

// register indices; the byte address is four times the index
`define GPD_IDX_DRIVE_ENABLE       6'h00
`define GPD_IDX_DRIVE_ENABLE_SET   6'h01
`define GPD_IDX_DRIVE_ENABLE_CLEAR 6'h02
`define GPD_IDX_DRIVE_ENABLE_FLIP  6'h03
`define GPD_IDX_DRIVE_LEVEL        6'h04
`define GPD_IDX_DRIVE_LEVEL_SET    6'h05
`define GPD_IDX_DRIVE_LEVEL_CLEAR  6'h06
`define GPD_IDX_DRIVE_LEVEL_FLIP   6'h07
`define GPD_IDX_SENSED_LEVELS      6'h08
`define GPD_IDX_PIN_EVENT_FLAGS    6'h09
`define GPD_IDX_FLAG_CLEAR         6'h0A
`define GPD_IDX_FLAG_ENABLE        6'h0B
`define GPD_IDX_PER_PAD_CONTROL    6'h0C

// index field of the byte address
`define GPD_ADR_IDX_HI 7
`define GPD_ADR_IDX_LO 2

// width of one sense_select field
`define GPD_SENSE_W 3

// reset values
`define GPD_RST_BYTE        8'h00
`define GPD_RST_FLAG_ENABLE 8'hFF
`define GPD_RST_PAD_CONTROL 24'h00_0000
`define GPD_RST_OE_N        8'hFF
`define GPD_RST_BUF_EN      8'hFF

`endif

//--- hdl/gpd_pkg.sv
// types shared by the gpio port data block
package gpd_pkg;

  // sense_select codes of one pin
  typedef enum logic [2:0] {
    GPD_SENSE_FLAG_OFF  = 3'h0,
    GPD_SENSE_BOTH      = 3'h1,
    GPD_SENSE_RISE      = 3'h2,
    GPD_SENSE_FALL      = 3'h3,
    GPD_SENSE_INPUT_OFF = 3'h4,
    GPD_SENSE_LOW_LEVEL = 3'h5
  } gpd_sense_t;

  // classic wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } gpd_wb_req_t;

  // pad drive group
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe_n;
    logic [7:0] buf_en;
  } gpd_pad_drive_t;

endpackage

//--- hdl/gpd_port.sv
// eight-pin gpio port data path with wishbone register slave
//
// Contract
// - each drive_enable bit turns its pin's output driver on when set
// - drive_enable never touches the input buffer; only sense_select does
// - drive_enable_set write sets bits written one, zeros ignored
// - drive_enable_clear write clears bits written one, zeros ignored
// - drive_enable_flip write inverts bits written one, zeros ignored
// - reading any drive_enable alias returns drive_enable
// - drive_level bit sets pin level, seen only while driver enabled
// - drive_level_set write sets bits written one, zeros ignored
// - drive_level_clear write clears bits written one, zeros ignored
// - drive_level_flip write inverts bits written one, zeros ignored
// - reading any drive_level alias returns drive_level
// - sensed_levels shows each pin level while its input buffer is on
// - writing one to sensed_levels inverts the matching drive_level bit
// - with input buffer off the pin is not sampled, bit holds
// - pin event flag sets when pin matches its sense_select condition
// - writing one to an event flag clears it, zero leaves it
// - interrupt stays high while any enabled event flag is set
// - code 4 disables flag and buffer, code 0 disables flag only
`timescale 1ns/10ps
`include "gpd_defs.svh"

module gpd_port (
  // clock and reset
  input  wire logic                   sys_clk_in,
  input  wire logic                   rstn_in,
  // wishbone slave
  input  wire gpd_pkg::gpd_wb_req_t   wb_req_in,
  output logic                        wb_ack_out,
  output logic [31:0]                 wb_dat_out,
  // pads
  input  wire logic [7:0]             pad_in,
  output gpd_pkg::gpd_pad_drive_t     pad_out,
  // interrupt
  output logic                        irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]  drive_enable_q;
  logic [7:0]  drive_enable_d;
  logic [7:0]  drive_level_q;
  logic [7:0]  drive_level_d;
  logic [7:0]  sensed_levels_q;
  logic [7:0]  pin_event_flags_q;
  logic [7:0]  pin_event_flags_d;
  logic [7:0]  flag_enable_q;
  logic [23:0] per_pad_control_q;
  logic [7:0]  sync1_q;
  logic [7:0]  sync2_q;
  logic [7:0]  prev_q;
  logic [7:0]  buf_en;
  logic [7:0]  pin_event;
  logic [7:0]  buf_en_q;
  logic [7:0]  oe_n_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic       take;
  logic       wr;
  logic       wr0;
  logic [5:0] idx;
  logic [7:0] wbyte;

  assign take  = wb_req_in.cyc & wb_req_in.stb & ~ack_q;
  assign wr    = take & wb_req_in.we;
  assign wr0   = wr & wb_req_in.sel[0];
  assign idx   = wb_req_in.adr[`GPD_ADR_IDX_HI:`GPD_ADR_IDX_LO];
  assign wbyte = wb_req_in.dat[7:0];

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (take && !wb_req_in.we) begin
      unique case (idx)
        `GPD_IDX_DRIVE_ENABLE, `GPD_IDX_DRIVE_ENABLE_SET,
        `GPD_IDX_DRIVE_ENABLE_CLEAR, `GPD_IDX_DRIVE_ENABLE_FLIP: begin
          rdata_q <= {24'h00_0000, drive_enable_q};
        end
        `GPD_IDX_DRIVE_LEVEL, `GPD_IDX_DRIVE_LEVEL_SET,
        `GPD_IDX_DRIVE_LEVEL_CLEAR, `GPD_IDX_DRIVE_LEVEL_FLIP: begin
          rdata_q <= {24'h00_0000, drive_level_q};
        end
        `GPD_IDX_SENSED_LEVELS:   rdata_q <= {24'h00_0000, sensed_levels_q};
        `GPD_IDX_PIN_EVENT_FLAGS: rdata_q <= {24'h00_0000, pin_event_flags_q};
        `GPD_IDX_FLAG_ENABLE:     rdata_q <= {24'h00_0000, flag_enable_q};
        `GPD_IDX_PER_PAD_CONTROL: rdata_q <= {8'h00, per_pad_control_q};
        default:                  rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive enable

  always_comb begin
    drive_enable_d = drive_enable_q;
    if (wr0) begin
      unique case (idx)
        `GPD_IDX_DRIVE_ENABLE:       drive_enable_d = wbyte;
        `GPD_IDX_DRIVE_ENABLE_SET:   drive_enable_d = drive_enable_q | wbyte;
        `GPD_IDX_DRIVE_ENABLE_CLEAR: drive_enable_d = drive_enable_q & ~wbyte;
        `GPD_IDX_DRIVE_ENABLE_FLIP:  drive_enable_d = drive_enable_q ^ wbyte;
        default:                     drive_enable_d = drive_enable_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      drive_enable_q <= `GPD_RST_BYTE;
      oe_n_q         <= `GPD_RST_OE_N;
    end else begin
      drive_enable_q <= drive_enable_d;
      oe_n_q         <= ~drive_enable_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive level

  always_comb begin
    drive_level_d = drive_level_q;
    if (wr0) begin
      unique case (idx)
        `GPD_IDX_DRIVE_LEVEL:       drive_level_d = wbyte;
        `GPD_IDX_DRIVE_LEVEL_SET:   drive_level_d = drive_level_q | wbyte;
        `GPD_IDX_DRIVE_LEVEL_CLEAR: drive_level_d = drive_level_q & ~wbyte;
        `GPD_IDX_DRIVE_LEVEL_FLIP:  drive_level_d = drive_level_q ^ wbyte;
        `GPD_IDX_SENSED_LEVELS:     drive_level_d = drive_level_q ^ wbyte;
        default:                    drive_level_d = drive_level_q;
      endcase
    end
  end

  // level is presented always; the pad only shows it while oe_n is low
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      drive_level_q <= `GPD_RST_BYTE;
    end else begin
      drive_level_q <= drive_level_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      per_pad_control_q <= `GPD_RST_PAD_CONTROL;
    end else if (wr && idx == `GPD_IDX_PER_PAD_CONTROL) begin
      if (wb_req_in.sel[0]) per_pad_control_q[7:0]   <= wb_req_in.dat[7:0];
      if (wb_req_in.sel[1]) per_pad_control_q[15:8]  <= wb_req_in.dat[15:8];
      if (wb_req_in.sel[2]) per_pad_control_q[23:16] <= wb_req_in.dat[23:16];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      flag_enable_q <= `GPD_RST_FLAG_ENABLE;
    end else if (wr0 && idx == `GPD_IDX_FLAG_ENABLE) begin
      flag_enable_q <= wbyte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and event detection

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_pin
    gpd_pkg::gpd_sense_t sense;
    assign sense = gpd_pkg::gpd_sense_t'(per_pad_control_q[i*`GPD_SENSE_W +: `GPD_SENSE_W]);
    // input buffer depends on sense_select alone, never on drive_enable
    assign buf_en[i] = (sense != gpd_pkg::GPD_SENSE_INPUT_OFF);

    always_comb begin
      pin_event[i] = 1'b0;
      if (buf_en[i]) begin
        unique case (sense)
          gpd_pkg::GPD_SENSE_BOTH:      pin_event[i] = sync2_q[i] ^ prev_q[i];
          gpd_pkg::GPD_SENSE_RISE:      pin_event[i] = sync2_q[i] & ~prev_q[i];
          gpd_pkg::GPD_SENSE_FALL:      pin_event[i] = ~sync2_q[i] & prev_q[i];
          gpd_pkg::GPD_SENSE_LOW_LEVEL: pin_event[i] = ~sync2_q[i];
          default:                      pin_event[i] = 1'b0;
        endcase
      end
    end

    always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
        sensed_levels_q[i] <= 1'b0;
        prev_q[i]          <= 1'b0;
      end else if (buf_en[i]) begin
        sensed_levels_q[i] <= sync2_q[i];
        prev_q[i]          <= sync2_q[i];
      end
      // buffer off: sample nothing, hold both the bit and the edge history
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event flags and interrupt

  logic [7:0] flag_clr;

  always_comb begin
    flag_clr = 8'h00;
    if (wr0 && (idx == `GPD_IDX_PIN_EVENT_FLAGS || idx == `GPD_IDX_FLAG_CLEAR)) begin
      flag_clr = wbyte;
    end
    // a new event in the clearing cycle wins
    pin_event_flags_d = (pin_event_flags_q & ~flag_clr) | pin_event;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pin_event_flags_q <= `GPD_RST_BYTE;
      irq_q             <= 1'b0;
    end else begin
      pin_event_flags_q <= pin_event_flags_d;
      irq_q             <= |(pin_event_flags_d & flag_enable_q);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      buf_en_q <= `GPD_RST_BUF_EN;
    end else begin
      buf_en_q <= buf_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign wb_ack_out     = ack_q;
  assign wb_dat_out     = rdata_q;
  assign pad_out.level  = drive_level_q;
  assign pad_out.oe_n   = oe_n_q;
  assign pad_out.buf_en = buf_en_q;
  assign irq_out        = irq_q;

endmodule

//--- dv/gpd_port_sva.sv
// assertion checker for the gpio port data block
`timescale 1ns/10ps
module gpd_port_sva (
  // clock and reset
  input wire logic                    sys_clk_in,
  input wire logic                    rstn_in,
  // wishbone
  input wire gpd_pkg::gpd_wb_req_t    wb_req_in,
  input wire logic                    wb_ack_out,
  input wire logic [31:0]             wb_dat_out,
  // pads and interrupt
  input wire logic [7:0]              pad_in,
  input wire gpd_pkg::gpd_pad_drive_t pad_out,
  input wire logic                    irq_out
);
  wire       tk = wb_req_in.cyc & wb_req_in.stb & ~wb_ack_out;
  wire       wr = tk & wb_req_in.we & wb_req_in.sel[0];
  wire       rd = tk & ~wb_req_in.we;
  wire [5:0] ix = wb_req_in.adr[7:2];
  wire [7:0] d  = wb_req_in.dat[7:0];
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_take; tk; endsequence
  sequence s_answer; wb_ack_out ##1 !wb_ack_out; endsequence
  a_ack_answer: assert property (s_take |=> s_answer)
    else $error("ack not a pulse one cycle after take");
  a_enable_write: assert property (wr && ix == 6'h00 |=> pad_out.oe_n == ~$past(d))
    else $error("drive enable write wrong");
  a_level_set: assert property (wr && ix == 6'h05 |=> pad_out.level == ($past(pad_out.level) | $past(d)))
    else $error("level set wrong");
  a_level_clear: assert property (wr && ix == 6'h06 |=> pad_out.level == ($past(pad_out.level) & ~$past(d)))
    else $error("level clear wrong");
  a_enable_set: assert property (wr && ix == 6'h01 |=> pad_out.oe_n == ($past(pad_out.oe_n) & ~$past(d)))
    else $error("set alias wrong");
  a_enable_clear: assert property (wr && ix == 6'h02 |=> pad_out.oe_n == ($past(pad_out.oe_n) | $past(d)))
    else $error("clear alias wrong");
  a_enable_flip: assert property (wr && ix == 6'h03 |=> pad_out.oe_n == ($past(pad_out.oe_n) ^ $past(d)))
    else $error("flip alias wrong");
  a_level_flip: assert property (wr && (ix == 6'h07 || ix == 6'h08) |=>
    pad_out.level == ($past(pad_out.level) ^ $past(d))) else $error("level flip wrong");
  a_alias_read: assert property (rd && ix inside {6'h01, 6'h02, 6'h03} |=>
    wb_dat_out == {24'h00_0000, ~$past(pad_out.oe_n)}) else $error("alias read wrong");
  a_level_read: assert property (rd && ix inside {6'h05, 6'h06, 6'h07} |=>
    wb_dat_out == {24'h00_0000, $past(pad_out.level)}) else $error("level alias read wrong");
  a_buf_keep: assert property (wr && ix < 6'h04 |=> $stable(pad_out.buf_en))
    else $error("buffer enable moved");
  a_irq_hold: assert property ($fell(irq_out) |-> $past(wr) || $past(wr, 2))
    else $error("interrupt dropped without a write");
endmodule
bind gpd_port gpd_port_sva u_sva (
  .sys_clk_in (sys_clk_in),
  .rstn_in    (rstn_in),
  .wb_req_in  (wb_req_in),
  .wb_ack_out (wb_ack_out),
  .wb_dat_out (wb_dat_out),
  .pad_in     (pad_in),
  .pad_out    (pad_out),
  .irq_out    (irq_out)
);

//--- dv/tb_gpd_port.sv
// self-checking bench for the gpio port data block
`timescale 1ns/10ps
module tb_gpd_port;
  logic                    sys_clk_in  = 1'b0;
  logic                    rstn_in     = 1'b0;
  gpd_pkg::gpd_wb_req_t    wb_req      = '0;
  logic                    wb_ack_out;
  logic [31:0]             wb_dat_out;
  logic [7:0]              pad_in      = 8'h00;
  gpd_pkg::gpd_pad_drive_t pad_out;
  logic                    irq_out;
  logic [31:0]             q;
  int                      miscompares = 0;
  int                      checked     = 0;
  int                      cycles      = 0;

  always #20 sys_clk_in = ~sys_clk_in;

  gpd_port u_dut (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .wb_req_in  (wb_req),
    .wb_ack_out (wb_ack_out),
    .wb_dat_out (wb_dat_out),
    .pad_in     (pad_in),
    .pad_out    (pad_out),
    .irq_out    (irq_out)
  );

  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge sys_clk_in);
    wb_req <= '{1'b1, 1'b1, w, {24'h00_0000, a, 2'b00}, s, d};
    do @(posedge sys_clk_in); while (wb_ack_out !== 1'b1);
    q = wb_dat_out;
    wb_req <= '0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h00_0000, d}, 4'h1);
  endtask

  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'hF);
    chk(q, {24'h00_0000, e});
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(32'(pad_out.oe_n), 32'h0000_00FF);
    chk(32'(pad_out.level), 32'h0000_0000);
    chk(32'(irq_out), 32'h0000_0000);
    rc(6'h00, 8'h00);
    rc(6'h04, 8'h00);
    rc(6'h08, 8'h00);
    rc(6'h09, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_enable();
    wr(6'h00, 8'hA5);
    chk(32'(pad_out.oe_n), 32'h0000_005A);
    wr(6'h01, 8'h0F);
    chk(32'(pad_out.oe_n), 32'h0000_0050);
    rc(6'h01, 8'hAF);
    rc(6'h02, 8'hAF);
    rc(6'h03, 8'hAF);
    wr(6'h02, 8'h81);
    rc(6'h00, 8'h2E);
    wr(6'h03, 8'hFF);
    rc(6'h00, 8'hD1);
    wr(6'h3F, 8'h00);
    rc(6'h3F, 8'h00);
    rc(6'h00, 8'hD1);
    chk(32'(pad_out.buf_en), 32'h0000_00FF);
    $display("drive enable test done");
  endtask

  task automatic t_level();
    wr(6'h04, 8'h3C);
    wr(6'h05, 8'h01);
    rc(6'h04, 8'h3D);
    wr(6'h06, 8'h30);
    rc(6'h05, 8'h0D);
    wr(6'h07, 8'h0F);
    rc(6'h06, 8'h02);
    wr(6'h08, 8'h03);
    chk(32'(pad_out.level), 32'h0000_0001);
    rc(6'h07, 8'h01);
    $display("drive level test done");
  endtask

  task automatic t_sense();
    pad_in <= 8'h55;
    idle(5);
    rc(6'h08, 8'h55);
    bus(1'b1, 6'h0C, 32'h0000_0004, 4'h7);
    idle(1);
    chk(32'(pad_out.buf_en), 32'h0000_00FE);
    pad_in <= 8'h54;
    idle(5);
    rc(6'h08, 8'h55);
    bus(1'b1, 6'h0C, 32'h0000_0000, 4'h7);
    idle(5);
    rc(6'h08, 8'h54);
    $display("sense test done");
  endtask

  task automatic t_irq();
    pad_in <= 8'h0A;
    bus(1'b1, 6'h0C, 32'h0000_0A5A, 4'h7);
    idle(5);
    wr(6'h09, 8'hFF);
    rc(6'h09, 8'h00);
    pad_in <= 8'h15;
    idle(5);
    rc(6'h09, 8'h0F);
    chk(32'(irq_out), 32'h0000_0001);
    wr(6'h0B, 8'h00);
    idle(2);
    chk(32'(irq_out), 32'h0000_0000);
    wr(6'h0B, 8'hFF);
    idle(2);
    chk(32'(irq_out), 32'h0000_0001);
    wr(6'h09, 8'h07);
    rc(6'h09, 8'h08);
    pad_in <= 8'h1D;
    idle(5);
    wr(6'h0A, 8'h08);
    idle(2);
    rc(6'h09, 8'h00);
    chk(32'(irq_out), 32'h0000_0000);
    $display("interrupt test done");
  endtask

  ////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    repeat (16) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    t_reset();
    t_enable();
    t_level();
    t_sense();
    t_irq();
    conclude();
  end
endmodule
